// ===== cadc_sequencer.v
// Integration sequencer with double-sampling correction and conversion averaging.
`timescale 1ns/10ps
`default_nettype none
`include "cadc_map.vh"

module cadc_sequencer (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        sys_reset_n,
    input  wire        integration_cycle_strobe_n,
    input  wire        cfg_sclk,
    input  wire        cfg_sdata,
    input  wire [19:0] sample_data,
    output reg  [20:0] conv_data_reg,
    output reg         conv_valid_reg,
    output reg         integ_reset_reg,
    output reg         acquire_reg,
    output reg         double_sample_correction_reg,
    output reg         twos_complement_format_reg,
    output reg         bipolar_range_reg,
    output reg         running_reg
);

    // -------------------------------------------------------------------------
    // States, one-hot
    // -------------------------------------------------------------------------
    localparam [5:0] ST_IDLE  = 6'h01;   // Waiting for the first strobe release.
    localparam [5:0] ST_RST   = 6'h02;   // One reset clock of an integration.
    localparam [5:0] ST_ACQ   = 6'h04;   // Signal acquisition clocks.
    localparam [5:0] ST_INIT  = 6'h08;   // Oversampling the initial point.
    localparam [5:0] ST_MEAS  = 6'h10;   // Integrating until the strobe ends it.
    localparam [5:0] ST_FINAL = 6'h20;   // Oversampling the final point.

    // -------------------------------------------------------------------------
    // Functions
    // -------------------------------------------------------------------------

    // Count code to shift amount: codes 0..7 give 2^code, top bit set gives 256.
    function [3:0] cnt_shift;
        input [3:0] code;
        begin
            cnt_shift = code[3] ? 4'h8 : {1'b0, code[2:0]};
        end
    endfunction

    // Average of an oversample sum: divide by 2^shift, keep twenty bits.
    function [19:0] os_avg;
        input [27:0] sum;
        input [3:0]  sh;
        reg   [27:0] t;
        begin
            t = sum >> sh;
            os_avg = t[19:0];
        end
    endfunction

    // -------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------
    reg  [3:0]  sync1_reg;       // First synchroniser stage of the four pins.
    reg  [3:0]  sync2_reg;       // Second synchroniser stage.
    reg         sclk_d_reg;      // Delayed serial clock for edge detection.
    reg         strb_d_reg;      // Delayed strobe for edge detection.
    reg  [5:0]  state_reg;       // Sequencer state.
    reg  [1:0]  acq_sel_reg;     // Active acquisition select.
    reg  [3:0]  m_sh_reg;        // Active oversample shift.
    reg  [3:0]  l_sh_reg;        // Active integration count shift.
    reg  [4:0]  cnt_reg;         // Acquisition clock counter.
    reg  [8:0]  os_cnt_reg;      // Oversamples left minus one.
    reg  [27:0] os_sum_reg;      // Oversample accumulator.
    reg  [19:0] init_pt_reg;     // Initial data point.
    reg  [8:0]  int_cnt_reg;     // Integrations done in this conversion.
    reg  [28:0] conv_acc_reg;    // Signed sum of integration results.
    wire [`CADC_CFG_W-1:0] cfg_word;   // Shifted configuration word.
    wire        sys_rst_act;     // System reset asserted (synchronised).
    wire        strb_rise;       // Strobe released: an integration boundary.
    wire        sclk_rise;       // Serial clock rising edge.
    wire [27:0] os_sum_now;      // Accumulator including this cycle's sample.
    wire [8:0]  m_last;          // Oversample count minus one.
    wire [8:0]  l_last;          // Integration count minus one.
    wire [19:0] final_pt;        // Final data point.
    wire [20:0] int_result;      // Result of one integration.
    wire [28:0] conv_total;      // Conversion sum with this integration.
    wire [28:0] conv_avg;        // Conversion sum averaged over L.
    wire [4:0]  acq_clks;        // Acquisition clocks for the selected code.
    wire        corr_on;         // Double-sampling correction active.

    // -------------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // -------------------------------------------------------------------------

    // Each of the four control pins passes two flip-flops; only the second stage is read. sample_data is not synchronised.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg  <= 4'h0;
            sync2_reg  <= 4'h0;
            sclk_d_reg <= 1'b0;
            strb_d_reg <= 1'b0;
        end else begin
            sync1_reg  <= {cfg_sdata, cfg_sclk, integration_cycle_strobe_n, sys_reset_n};
            sync2_reg  <= sync1_reg;
            sclk_d_reg <= sync2_reg[2];
            strb_d_reg <= sync2_reg[1];
        end
    end

    assign sys_rst_act = ~sync2_reg[0];
    assign strb_rise   = sync2_reg[1] & ~strb_d_reg;
    assign sclk_rise   = sync2_reg[2] & ~sclk_d_reg;

    // -------------------------------------------------------------------------
    // Configuration loader
    // -------------------------------------------------------------------------
    cadc_cfg_shift u_cfg_shift (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .hold_active (sys_rst_act),
        .shift_en    (sclk_rise),
        .shift_bit   (sync2_reg[3]),
        .word_reg    (cfg_word)
    );

    // -------------------------------------------------------------------------
    // Datapath arithmetic
    // -------------------------------------------------------------------------

    // Acquisition clocks that follow the single reset clock.
    assign acq_clks = (acq_sel_reg == `CADC_ACQ_32) ? `CADC_ACQ_CLK_32 :
                      (acq_sel_reg == `CADC_ACQ_16) ? `CADC_ACQ_CLK_16 :
                      `CADC_ACQ_CLK_1;
    assign corr_on    = (acq_sel_reg != `CADC_ACQ_NONE);
    assign os_sum_now = os_sum_reg + {8'h00, sample_data};
    assign m_last     = (9'h001 << m_sh_reg) - 9'h001;
    assign l_last     = (9'h001 << l_sh_reg) - 9'h001;
    assign final_pt   = os_avg(os_sum_now, m_sh_reg);
    // The initial point is removed from the final point when correcting.
    assign int_result = corr_on ? ({1'b0, final_pt} - {1'b0, init_pt_reg})
                               : {1'b0, final_pt};
    assign conv_total = conv_acc_reg + {{8{int_result[20]}}, int_result};
    assign conv_avg   = $signed(conv_total) >>> l_sh_reg;

    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------

    // System reset returns to idle; the first strobe release latches the
    // configuration and opens the first integration.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg                    <= ST_IDLE;
            acq_sel_reg                  <= `CADC_ACQ_NONE;
            m_sh_reg                     <= `CADC_CNT_RESET;
            l_sh_reg                     <= `CADC_CNT_RESET;
            cnt_reg                      <= 5'h00;
            os_cnt_reg                   <= 9'h000;
            os_sum_reg                   <= 28'h0000000;
            init_pt_reg                  <= 20'h00000;
            int_cnt_reg                  <= 9'h000;
            conv_acc_reg                 <= 29'h00000000;
            conv_data_reg                <= 21'h000000;
            conv_valid_reg               <= 1'b0;
            integ_reset_reg              <= 1'b0;
            acquire_reg                  <= 1'b0;
            double_sample_correction_reg <= 1'b0;
            twos_complement_format_reg   <= 1'b0;
            bipolar_range_reg            <= 1'b0;
            running_reg                  <= 1'b0;
        end else if (sys_rst_act) begin
            // Held in system reset: everything parks, the loader may shift.
            state_reg       <= ST_IDLE;
            conv_valid_reg  <= 1'b0;
            integ_reset_reg <= 1'b0;
            acquire_reg     <= 1'b0;
            running_reg     <= 1'b0;
        end else begin
            conv_valid_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (strb_rise) begin
                        // Settings take effect only now.
                        acq_sel_reg <= cfg_word[`CADC_ACQ_HI:`CADC_ACQ_LO];
                        m_sh_reg    <= cnt_shift(cfg_word[`CADC_OSM_HI:`CADC_OSM_LO]);
                        l_sh_reg    <= cnt_shift(cfg_word[`CADC_INTL_HI:`CADC_INTL_LO]);
                        double_sample_correction_reg <=
                            (cfg_word[`CADC_ACQ_HI:`CADC_ACQ_LO] != `CADC_ACQ_NONE);
                        twos_complement_format_reg <=
                            (cfg_word[`CADC_FMT_BIT] == `CADC_FMT_TWOS);
                        bipolar_range_reg <=
                            (cfg_word[`CADC_RANGE_BIT] == `CADC_RANGE_BIPOLAR);
                        int_cnt_reg     <= 9'h000;
                        conv_acc_reg    <= 29'h00000000;
                        integ_reset_reg <= 1'b1;
                        running_reg     <= 1'b1;
                        state_reg       <= ST_RST;
                    end
                end
                ST_RST: begin
                    // Exactly one reset clock per integration.
                    integ_reset_reg <= 1'b0;
                    cnt_reg         <= acq_clks - `CADC_RESET_CLKS;
                    os_cnt_reg      <= m_last;
                    os_sum_reg      <= 28'h0000000;
                    if (acq_clks != 5'h00) begin
                        acquire_reg <= 1'b1;
                        state_reg   <= ST_ACQ;
                    end else if (corr_on) begin
                        state_reg <= ST_INIT;
                    end else begin
                        state_reg <= ST_MEAS;
                    end
                end
                ST_ACQ: begin
                    // Count down the acquisition clocks.
                    if (cnt_reg == 5'h00) begin
                        acquire_reg <= 1'b0;
                        state_reg   <= ST_INIT;
                    end else begin
                        cnt_reg <= cnt_reg - 5'h01;
                    end
                end
                ST_INIT: begin
                    // Oversample the initial point over M clocks.
                    if (os_cnt_reg == 9'h000) begin
                        init_pt_reg <= os_avg(os_sum_now, m_sh_reg);
                        os_sum_reg  <= 28'h0000000;
                        state_reg   <= ST_MEAS;
                    end else begin
                        os_sum_reg <= os_sum_now;
                        os_cnt_reg <= os_cnt_reg - 9'h001;
                    end
                end
                ST_MEAS: begin
                    // The strobe release closes this integration.
                    if (strb_rise) begin
                        os_cnt_reg <= m_last;
                        os_sum_reg <= 28'h0000000;
                        state_reg  <= ST_FINAL;
                    end
                end
                ST_FINAL: begin
                    if (os_cnt_reg == 9'h000) begin
                        integ_reset_reg <= 1'b1;
                        state_reg       <= ST_RST;
                        if (int_cnt_reg == l_last) begin
                            // Last integration: publish the averaged conversion.
                            int_cnt_reg    <= 9'h000;
                            conv_acc_reg   <= 29'h00000000;
                            conv_valid_reg <= 1'b1;
                            if (twos_complement_format_reg) begin
                                conv_data_reg <= conv_avg[20:0];
                            end else if (bipolar_range_reg) begin
                                conv_data_reg <= {1'b0, conv_avg[19:0] + `CADC_SB_OFFSET};
                            end else if (conv_avg[28]) begin
                                conv_data_reg <= 21'h000000;
                            end else begin
                                conv_data_reg <= {1'b0, conv_avg[19:0]};
                            end
                        end else begin
                            int_cnt_reg  <= int_cnt_reg + 9'h001;
                            conv_acc_reg <= conv_total;
                        end
                    end else begin
                        os_sum_reg <= os_sum_now;
                        os_cnt_reg <= os_cnt_reg - 9'h001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // cadc_sequencer
`default_nettype wire

// ===== cadc_map.vh
// Constants for the charge converter control block: field layout, codes and phase counts.
`ifndef CADC_MAP_VH
`define CADC_MAP_VH

// -----------------------------------------------------------------------------
// Configuration word layout
// -----------------------------------------------------------------------------
`define CADC_CFG_W        12
`define CADC_CFG_RESET    12'h000
`define CADC_CNT_RESET    4'h0
`define CADC_ACQ_HI       11
`define CADC_ACQ_LO       10
`define CADC_OSM_HI       9
`define CADC_OSM_LO       6
`define CADC_INTL_HI      5
`define CADC_INTL_LO      2
`define CADC_RANGE_BIT    1
`define CADC_FMT_BIT      0

// -----------------------------------------------------------------------------
// Acquisition select codes and acquisition clock counts after the reset clock
// -----------------------------------------------------------------------------
`define CADC_ACQ_NONE     2'h0
`define CADC_ACQ_1        2'h1
`define CADC_ACQ_16       2'h2
`define CADC_ACQ_32       2'h3
`define CADC_ACQ_CLK_1    5'h00
`define CADC_ACQ_CLK_16   5'h0f
`define CADC_ACQ_CLK_32   5'h1f
`define CADC_RESET_CLKS   5'h01

// -----------------------------------------------------------------------------
// Field values and output coding
// -----------------------------------------------------------------------------
`define CADC_RANGE_BIPOLAR 1'h1
`define CADC_FMT_TWOS      1'h1
`define CADC_SB_OFFSET     20'h80000

`endif

// ===== cadc_cfg_shift.v
// Serial loader that collects the twelve-bit configuration word.
`timescale 1ns/10ps
`default_nettype none
`include "cadc_map.vh"

module cadc_cfg_shift (
    input  wire                     ref_clk,
    input  wire                     rst_n,
    input  wire                     hold_active,
    input  wire                     shift_en,
    input  wire                     shift_bit,
    output reg  [`CADC_CFG_W-1:0]   word_reg
);

    // -------------------------------------------------------------------------
    // Shift register
    // -------------------------------------------------------------------------

    // Bits enter at the bottom, so the first bit sent ends in the top field.
    // Shifting is only allowed while the system reset is held.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_reg <= `CADC_CFG_RESET;
        end else if (hold_active && shift_en) begin
            word_reg <= {word_reg[`CADC_CFG_W-2:0], shift_bit};
        end
    end

endmodule // cadc_cfg_shift
`default_nettype wire

// ===== cadc_seq_checker_properties.sv
// Port checker for the integration sequencer, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module cadc_seq_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        sys_reset_n,
    input wire logic [20:0] conv_data_reg,
    input wire logic        conv_valid_reg,
    input wire logic        integ_reset_reg,
    input wire logic        acquire_reg,
    input wire logic        double_sample_correction_reg,
    input wire logic        twos_complement_format_reg,
    input wire logic        bipolar_range_reg,
    input wire logic        running_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------------
    // Length of the current acquisition run.
    // ------------------------------------------------------------------
    logic [5:0] acq_run_reg; // Consecutive acquisition clocks seen.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            acq_run_reg <= 6'h00;
        else
            acq_run_reg <= acquire_reg ? acq_run_reg + 6'h01 : 6'h00;
    end
    a_reset_single: assert property ($rose(integ_reset_reg) |=> !integ_reset_reg)
        else $error("integration reset lasted more than one clock");
    a_acq_follows: assert property ($rose(acquire_reg) |-> $past(integ_reset_reg))
        else $error("acquisition did not follow the reset clock");
    a_acq_length: assert property ($fell(acquire_reg) && running_reg |->
        (acq_run_reg == 6'h0f || acq_run_reg == 6'h1f))
        else $error("acquisition length was neither 15 nor 31");
    a_acq_needs_corr: assert property (acquire_reg |-> double_sample_correction_reg)
        else $error("acquisition without correction enabled");
    a_valid_single: assert property (conv_valid_reg |=> !conv_valid_reg)
        else $error("result pulse longer than one clock");
    a_data_with_valid: assert property (!$stable(conv_data_reg) |-> conv_valid_reg)
        else $error("result changed without its pulse");
    a_valid_then_reset: assert property (conv_valid_reg |-> integ_reset_reg)
        else $error("next integration did not open with the result");
    a_start_in_reset: assert property ($rose(running_reg) |-> integ_reset_reg)
        else $error("start did not open with a reset clock");
    a_cfg_frozen: assert property (running_reg && $past(running_reg) |->
        $stable(double_sample_correction_reg) && $stable(twos_complement_format_reg)
        && $stable(bipolar_range_reg))
        else $error("settings changed while running");
    a_sys_reset_idle: assert property (!sys_reset_n [*5] |->
        !running_reg && !acquire_reg && !integ_reset_reg)
        else $error("sequencer active during system reset");
    a_idle_quiet: assert property (!running_reg |-> !acquire_reg && !conv_valid_reg)
        else $error("activity while not running");
endmodule // cadc_seq_checker
bind cadc_sequencer cadc_seq_checker cadc_seq_checker_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .sys_reset_n(sys_reset_n),
    .conv_data_reg(conv_data_reg), .conv_valid_reg(conv_valid_reg),
    .integ_reset_reg(integ_reset_reg), .acquire_reg(acquire_reg),
    .double_sample_correction_reg(double_sample_correction_reg),
    .twos_complement_format_reg(twos_complement_format_reg),
    .bipolar_range_reg(bipolar_range_reg), .running_reg(running_reg));
`default_nettype wire

// ===== cadc_host_model.sv
// Host controller model that loads the setup word and paces integrations.
`timescale 1ns/10ps
`default_nettype none
module cadc_host_model (
    input  wire logic ref_clk,
    output var  logic sys_reset_n,
    output var  logic integration_cycle_strobe_n,
    output var  logic cfg_sclk,
    output var  logic cfg_sdata
);
    // Power-up state: both control inputs active.
    initial begin
        sys_reset_n = 1'b0;
        integration_cycle_strobe_n = 1'b0;
        cfg_sclk = 1'b0;
        cfg_sdata = 1'b0;
    end
    // Waits whole clocks, then steps just past the edge.
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Shifts the word first bit first while both inputs stay low.
    task automatic setup(input logic [11:0] word);
        hold(1);
        sys_reset_n = 1'b0;
        integration_cycle_strobe_n = 1'b0;
        hold(4);
        for (int i = 11; i >= 0; i--) begin
            cfg_sdata = word[i];
            hold(4);
            cfg_sclk = 1'b1;
            hold(4);
            cfg_sclk = 1'b0;
        end
        cfg_sdata = ~word[0]; // The idle data line shows the inverse.
        hold(4);
        sys_reset_n = 1'b1;
        hold(6);
    endtask
    // First release of the strobe starts operation.
    task automatic start();
        integration_cycle_strobe_n = 1'b1;
    endtask
    // A low pulse of the strobe closes one integration. Counts stay within 256.
    task automatic end_integ();
        integration_cycle_strobe_n = 1'b0;
        hold(4);
        integration_cycle_strobe_n = 1'b1;
    endtask
endmodule // cadc_host_model
`default_nettype wire

// ===== test_cadc_sequencer.sv
// Self-checking testbench of the integration sequencer.
`timescale 1ns/10ps
`default_nettype none
module test_cadc_sequencer;
    logic        ref_clk, rst_n, sys_reset_n, strobe_n, cfg_sclk, cfg_sdata;
    logic [19:0] sample_data;
    logic [20:0] conv_data_reg;
    logic        conv_valid_reg, integ_reset_reg, acquire_reg, running_reg;
    logic        dsc_reg, twos_reg, bip_reg, prev_fmt;
    int          err_total, n_compared, cycles, acq_cnt, lat, lat_ref;
    cadc_sequencer cadc_sequencer_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .sys_reset_n(sys_reset_n), .integration_cycle_strobe_n(strobe_n),
        .cfg_sclk(cfg_sclk), .cfg_sdata(cfg_sdata), .sample_data(sample_data),
        .conv_data_reg(conv_data_reg), .conv_valid_reg(conv_valid_reg),
        .integ_reset_reg(integ_reset_reg), .acquire_reg(acquire_reg),
        .double_sample_correction_reg(dsc_reg), .twos_complement_format_reg(twos_reg),
        .bipolar_range_reg(bip_reg), .running_reg(running_reg));
    cadc_host_model host_model_inst (.ref_clk(ref_clk), .sys_reset_n(sys_reset_n),
        .integration_cycle_strobe_n(strobe_n), .cfg_sclk(cfg_sclk), .cfg_sdata(cfg_sdata));
    // Clock, acquisition cycle count and the hang limit.
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (acquire_reg === 1'b1)
            acq_cnt <= acq_cnt + 1;
        if (cycles == 30000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkn(input string nm, input int e, input int g);
        n_compared++;
        if (g != e) begin
            err_total++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One conversion: load, start, close each integration, check result.
    task automatic run(input logic [11:0] w, input logic [19:0] iv, f0, f1,
                       input logic [20:0] ed);
        int n_int;
        n_int = w[5] ? 256 : (1 << w[4:2]);
        sample_data = iv;
        host_model_inst.setup(w);
        chk("running_pre", 1'b0, running_reg);
        chk("format_pre", prev_fmt, twos_reg);
        acq_cnt = 0;
        host_model_inst.start();
        for (int i = 0; i < n_int; i++) begin
            repeat ((n_int > 2) ? 8 : 330) @(posedge ref_clk);
            #1;
            sample_data = i[0] ? f1 : f0;
            host_model_inst.end_integ();
        end
        lat = 0;
        while (conv_valid_reg !== 1'b1 && lat < 600) begin
            @(posedge ref_clk);
            #1;
            lat++;
        end
        chk("conv_data", ed, conv_data_reg);
        chk("correction", w[11:10] != 2'h0, dsc_reg);
        chk("twos_format", w[0], twos_reg);
        chk("bipolar", w[1], bip_reg);
        chkn("acq_clocks", (w[11:10] == 2'h2) ? 15 : (w[11:10] == 2'h3) ? 31 : 0, acq_cnt);
        prev_fmt = w[0];
    endtask
    // Main sequence.
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        sample_data = 20'h00000;
        prev_fmt = 1'b0;
        {err_total, n_compared, cycles, acq_cnt, lat, lat_ref} = '0;
        repeat (4) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        run(12'h401, 20'h00100, 20'h00350, 20'h00000, 21'h000250);
        lat_ref = lat;
        run(12'h045, 20'h12345, 20'h00100, 20'h00300, 21'h000200);
        run(12'h400, 20'h00500, 20'h00100, 20'h00000, 21'h000000);
        run(12'h403, 20'h00300, 20'h00100, 20'h00000, 21'h1ffe00);
        run(12'h002, 20'h00000, 20'h00010, 20'h00000, 21'h080010);
        run(12'h801, 20'h00020, 20'h00020, 20'h00000, 21'h000000);
        run(12'hc01, 20'h00020, 20'h00020, 20'h00000, 21'h000000);
        run(12'h4c1, 20'h00040, 20'h00040, 20'h00000, 21'h000000);
        chkn("final_len_8", lat_ref + 7, lat);
        run(12'h601, 20'h00040, 20'h00040, 20'h00000, 21'h000000);
        chkn("final_len_256", lat_ref + 255, lat);
        run(12'h021, 20'h00000, 20'h00100, 20'h00300, 21'h000200);
        end_of_test();
    end
endmodule // test_cadc_sequencer
`default_nettype wire
